// ### pkg/arc_pkg.sv
package arc_pkg;
    // conversion command kinds presented by the command decoder
    typedef enum logic [3:0] {
        ARC_CMD_CELL = 4'h0,
        ARC_CMD_OWC = 4'h1,
        ARC_CMD_CST = 4'h2,
        ARC_CMD_AUXD = 4'h3,
        ARC_CMD_OWA = 4'h4,
        ARC_CMD_AST = 4'h5,
        ARC_CMD_STATD = 4'h6,
        ARC_CMD_SST = 4'h7,
        ARC_CMD_CAX = 4'h8,
        ARC_CMD_CSC = 4'h9,
        ARC_CMD_AUX = 4'hA,
        ARC_CMD_STAT = 4'hB
    } arc_cmd_t;

    // command request bundle
    typedef struct packed {
        arc_cmd_t kind;
        logic all_cells;
        logic multi_cal;
    } arc_req_t;

    // one stored result with its destination
    typedef struct packed {
        logic [2:0] slot;
        logic second_path;
        logic [15:0] value;
    } arc_res_t;

    localparam logic [15:0] ARC_FAULT_BASE = 16'hFF00;
    localparam logic [15:0] ARC_MAX_VALID = 16'hDFFF;
    localparam logic [3:0] ARC_FORCE_FLAGS = 4'hF;
    localparam int ARC_NIBBLES = 4;
    localparam int ARC_CELLS = 6;
    localparam int ARC_CLK_MHZ = 20;
    // fastest-mode timing in microseconds
    localparam int ARC_ALL_SLOT_US = 571;
    localparam int ARC_ALL_DONE_US = 913;
    localparam int ARC_ALL_DONE_MCAL_US = 2194;
    localparam int ARC_ONE_SLOT_US = 104;
    localparam int ARC_ONE_DONE_US = 265;
    localparam int ARC_ONE_DONE_MCAL_US = 381;
    localparam int ARC_ALL_SLOTS = 12;
    localparam int ARC_ONE_SLOTS = 2;
    // cycle counts derived from the clock rate
    localparam int ARC_ALL_SLOT_CYC = ARC_ALL_SLOT_US * ARC_CLK_MHZ;
    localparam int ARC_ALL_DONE_CYC = ARC_ALL_DONE_US * ARC_CLK_MHZ;
    localparam int ARC_ALL_DONE_MCAL_CYC = ARC_ALL_DONE_MCAL_US * ARC_CLK_MHZ;
    localparam int ARC_ONE_SLOT_CYC = ARC_ONE_SLOT_US * ARC_CLK_MHZ;
    localparam int ARC_ONE_DONE_CYC = ARC_ONE_DONE_US * ARC_CLK_MHZ;
    localparam int ARC_ONE_DONE_MCAL_CYC = ARC_ONE_DONE_MCAL_US * ARC_CLK_MHZ;
endpackage

// ### logic/arc_compare.sv
`timescale 1ns/1ps
// combinational compare of the two decimator words into a stored value
module arc_compare (
    input wire logic [15:0] primary_word,
    input wire logic [15:0] redundant_word,
    input wire logic check_en,
    input wire logic force_fail,
    output logic [15:0] stored_word
);
    logic [3:0] nib_flag; // per-nibble mismatch flags

    // one comparator per nibble
    genvar gi;
    generate
        for (gi = 0; gi < arc_pkg::ARC_NIBBLES; gi++)
        begin : g_nib
            assign nib_flag[gi] =
                |(primary_word[gi*4 +: 4] ^ redundant_word[gi*4 +: 4]);
        end
    endgenerate

    // pick plain value or fault word
    always_comb
    begin
        stored_word = primary_word;
        if (check_en && force_fail)
        begin
            // forced failure flags every nibble, never all zero
            stored_word = arc_pkg::ARC_FAULT_BASE |
                {12'h000, arc_pkg::ARC_FORCE_FLAGS};
        end
        else if (check_en && (nib_flag != 4'h0))
        begin
            // only reached with a nonzero flag set
            stored_word = arc_pkg::ARC_FAULT_BASE | {12'h000, nib_flag};
        end
        else if (primary_word > arc_pkg::ARC_MAX_VALID)
        begin
            // clamp keeps genuine data out of fault space
            stored_word = arc_pkg::ARC_MAX_VALID;
        end
    end
endmodule

// ### logic/arc_checker.sv
`timescale 1ns/1ps
// Notes on behaviour
// - redundancy for all but plain aux/status
// - cell check needs disable and second-path clear
// - modulator stream feeds both decimators
// - mismatch stores 0xFF0X instead of result
// - valid results stay within 0x0000..0xDFFF
// - low nibble flags per mismatching result nibble
// - fault word never has zero flags
// - force bit makes every comparison fail
// - disable bit stores ordinary value
// - second path converts each cell twice
// - second-path results go to groups A/B
// - second-path cells skip redundancy compare
// - all-cell second path: 12 slots, calibration
// - one-cell second path: two measurements
module arc_checker #(
    parameter int ALL_SLOT_CYC = arc_pkg::ARC_ALL_SLOT_CYC,
    parameter int ALL_DONE_CYC = arc_pkg::ARC_ALL_DONE_CYC,
    parameter int ALL_DONE_MCAL_CYC = arc_pkg::ARC_ALL_DONE_MCAL_CYC,
    parameter int ONE_SLOT_CYC = arc_pkg::ARC_ONE_SLOT_CYC,
    parameter int ONE_DONE_CYC = arc_pkg::ARC_ONE_DONE_CYC,
    parameter int ONE_DONE_MCAL_CYC = arc_pkg::ARC_ONE_DONE_MCAL_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire arc_pkg::arc_req_t cmd_req,
    input wire logic redundancy_disable_bit,
    input wire logic second_path_convert_bit,
    input wire logic force_redundancy_fail_bit,
    input wire logic mod_bit,
    input wire logic mod_bit_valid,
    input wire logic conv_done,
    input wire logic [15:0] primary_word,
    input wire logic [15:0] redundant_word,
    output logic primary_feed_reg,
    output logic redundant_feed_reg,
    output logic feed_valid_reg,
    output logic use_second_pins_reg,
    output logic busy_reg,
    output logic done_reg,
    output logic res_valid_reg,
    output arc_pkg::arc_res_t res_reg
);
    // sequencer states
    typedef enum logic [3:0] {
        ARC_IDLE = 4'b0001,
        ARC_PLAIN = 4'b0010,
        ARC_SLOTS = 4'b0100,
        ARC_CAL = 4'b1000
    } arc_state_t;

    arc_state_t state_reg; // sequencer state
    arc_pkg::arc_req_t req_reg; // latched command
    logic chk_reg; // redundancy compare active for this command
    logic second_reg; // second-path sequence active
    logic [31:0] tick_reg; // cycles since command start
    logic [3:0] slot_reg; // measurement slot index
    logic [31:0] slot_len; // slot spacing
    logic [31:0] done_at; // completion time
    logic [3:0] slot_cnt; // slots in this command
    logic is_cell; // command measures cell voltages
    logic wants_red; // command supports redundancy
    logic [15:0] stored_word; // compare result
    logic [2:0] cell_idx; // cell index of current slot

    // classify command kinds
    always_comb
    begin
        case (cmd_req.kind)
            arc_pkg::ARC_CMD_CELL, arc_pkg::ARC_CMD_OWC, arc_pkg::ARC_CMD_CST,
            arc_pkg::ARC_CMD_CAX, arc_pkg::ARC_CMD_CSC: is_cell = 1'b1;
            default: is_cell = 1'b0;
        endcase
        // plain aux and status never compare
        wants_red = !(cmd_req.kind == arc_pkg::ARC_CMD_AUX ||
                      cmd_req.kind == arc_pkg::ARC_CMD_STAT);
    end

    // timing selection for the second-path sequence
    always_comb
    begin
        if (req_reg.all_cells)
        begin
            slot_len = 32'(ALL_SLOT_CYC / arc_pkg::ARC_ALL_SLOTS);
            slot_cnt = 4'(arc_pkg::ARC_ALL_SLOTS);
            done_at = req_reg.multi_cal ? 32'(ALL_DONE_MCAL_CYC) : 32'(ALL_DONE_CYC);
        end
        else
        begin
            slot_len = 32'(ONE_SLOT_CYC / arc_pkg::ARC_ONE_SLOTS);
            slot_cnt = 4'(arc_pkg::ARC_ONE_SLOTS);
            done_at = req_reg.multi_cal ? 32'(ONE_DONE_MCAL_CYC) : 32'(ONE_DONE_CYC);
        end
    end

    // even slots use primary pins, odd slots the second pins
    assign cell_idx = req_reg.all_cells ? 3'(slot_reg >> 1) : 3'h0;

    arc_compare u_cmp (
        .primary_word(primary_word),
        .redundant_word(redundant_word),
        .check_en(chk_reg),
        .force_fail(force_redundancy_fail_bit),
        .stored_word(stored_word)
    );

    // modulator stream fans out to both decimators
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            primary_feed_reg <= 1'b0;
            redundant_feed_reg <= 1'b0;
            feed_valid_reg <= 1'b0;
        end
        else
        begin
            // both decimators get every bit, second-path slots included
            primary_feed_reg <= mod_bit;
            redundant_feed_reg <= mod_bit;
            feed_valid_reg <= mod_bit_valid && busy_reg;
        end
    end

    // command sequencer
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ARC_IDLE;
            req_reg <= '0;
            chk_reg <= 1'b0;
            second_reg <= 1'b0;
            tick_reg <= 32'h0000_0000;
            slot_reg <= 4'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            use_second_pins_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            case (state_reg)
                ARC_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        req_reg <= cmd_req;
                        busy_reg <= 1'b1;
                        tick_reg <= 32'h0000_0000;
                        slot_reg <= 4'h0;
                        if (is_cell && second_path_convert_bit)
                        begin
                            // second-path cells: no compare at all
                            second_reg <= 1'b1;
                            chk_reg <= 1'b0;
                            state_reg <= ARC_SLOTS;
                        end
                        else
                        begin
                            second_reg <= 1'b0;
                            chk_reg <= wants_red && !redundancy_disable_bit;
                            state_reg <= ARC_PLAIN;
                        end
                    end
                end
                ARC_PLAIN:
                begin
                    // timing owned by the converter, finish on its done
                    if (conv_done)
                    begin
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        state_reg <= ARC_IDLE;
                    end
                end
                ARC_SLOTS:
                begin
                    tick_reg <= tick_reg + 32'h0000_0001;
                    use_second_pins_reg <= slot_reg[0];
                    if (tick_reg == (32'(slot_reg) + 32'h1) * slot_len - 32'h1)
                    begin
                        slot_reg <= slot_reg + 4'h1;
                        if (slot_reg == slot_cnt - 4'h1)
                        begin
                            state_reg <= ARC_CAL;
                        end
                    end
                end
                ARC_CAL:
                begin
                    tick_reg <= tick_reg + 32'h0000_0001;
                    use_second_pins_reg <= 1'b0;
                    if (tick_reg >= done_at - 32'h1)
                    begin
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        second_reg <= 1'b0;
                        state_reg <= ARC_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ARC_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // result write-out with destination group
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            res_valid_reg <= 1'b0;
            res_reg <= '0;
        end
        else
        begin
            res_valid_reg <= conv_done && busy_reg;
            if (conv_done && busy_reg)
            begin
                res_reg.value <= stored_word;
                res_reg.second_path <= second_reg && slot_reg[0];
                res_reg.slot <= second_reg ? cell_idx : 3'h0;
            end
        end
    end
endmodule

// ### verification/arc_checker_asserts.sv
`timescale 1ns/1ps
// port-level checks of the redundancy checker
module arc_checker_asserts #(
    parameter int ALL_SLOT_CYC = 240,
    parameter int ALL_DONE_CYC = 400,
    parameter int ALL_DONE_MCAL_CYC = 800,
    parameter int ONE_SLOT_CYC = 40,
    parameter int ONE_DONE_CYC = 100,
    parameter int ONE_DONE_MCAL_CYC = 160
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire arc_pkg::arc_req_t cmd_req,
    input wire logic redundancy_disable_bit,
    input wire logic second_path_convert_bit,
    input wire logic force_redundancy_fail_bit,
    input wire logic mod_bit,
    input wire logic mod_bit_valid,
    input wire logic conv_done,
    input wire logic [15:0] primary_word,
    input wire logic [15:0] redundant_word,
    input wire logic primary_feed_reg,
    input wire logic redundant_feed_reg,
    input wire logic feed_valid_reg,
    input wire logic use_second_pins_reg,
    input wire logic busy_reg,
    input wire logic done_reg,
    input wire logic res_valid_reg,
    input wire arc_pkg::arc_res_t res_reg
);
    // done windows with a little slack for the start edge
    localparam int OD_LO = ONE_DONE_CYC - 4;
    localparam int OD_HI = ONE_DONE_CYC + 4;
    localparam int AD_LO = ALL_DONE_CYC - 4;
    localparam int AD_HI = ALL_DONE_CYC + 4;
    // second-pin slot starts one slot after the command, pins follow a cycle later
    localparam int PS_LO = ONE_SLOT_CYC / 2;
    localparam int PS_HI = ONE_SLOT_CYC / 2 + 2;
    logic [3:0] nib; // expected per-nibble mismatch flags
    logic plain; // compare enabled: disable and second-path bits clear
    assign nib = {primary_word[15:12] != redundant_word[15:12],
        primary_word[11:8] != redundant_word[11:8],
        primary_word[7:4] != redundant_word[7:4], primary_word[3:0] != redundant_word[3:0]};
    assign plain = !redundancy_disable_bit && !second_path_convert_bit;
    logic cell_kind; // command measures cell voltages
    // only cell commands take the slotted second-path sequence
    assign cell_kind = cmd_req.kind inside {arc_pkg::ARC_CMD_CELL, arc_pkg::ARC_CMD_OWC,
        arc_pkg::ARC_CMD_CST, arc_pkg::ARC_CMD_CAX, arc_pkg::ARC_CMD_CSC};
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence one_go;
        $rose(busy_reg) && second_path_convert_bit && cell_kind && !cmd_req.all_cells &&
            !cmd_req.multi_cal;
    endsequence
    sequence all_go;
        $rose(busy_reg) && second_path_convert_bit && cell_kind && cmd_req.all_cells &&
            !cmd_req.multi_cal;
    endsequence
    // the filters are only fed while a command runs
    feed_copy_a: assert property (mod_bit_valid && busy_reg |=> feed_valid_reg &&
        primary_feed_reg == $past(mod_bit) && redundant_feed_reg == $past(mod_bit))
        else $error("stream not fed to both filters");
    start_busy_a: assert property (cmd_valid && !busy_reg |=> busy_reg)
        else $error("command not taken");
    nibble_flags_a: assert property (conv_done && busy_reg && plain &&
        !force_redundancy_fail_bit && cmd_req.kind == arc_pkg::ARC_CMD_CELL && nib != 4'h0
        |=> res_valid_reg && res_reg.value == {12'hFF0, $past(nib)})
        else $error("wrong fault word");
    force_flags_a: assert property (conv_done && busy_reg && plain &&
        force_redundancy_fail_bit && cmd_req.kind == arc_pkg::ARC_CMD_CELL
        |=> res_reg.value == 16'hFF0F) else $error("forced fault missing");
    disable_plain_a: assert property (conv_done && busy_reg && redundancy_disable_bit &&
        primary_word <= 16'hDFFF |=> res_reg.value == $past(primary_word))
        else $error("disabled compare altered value");
    aux_plain_a: assert property (conv_done && busy_reg && cmd_req.kind ==
        arc_pkg::ARC_CMD_AUX && primary_word <= 16'hDFFF |=> res_reg.value == $past(primary_word))
        else $error("plain aux was compared");
    fault_form_a: assert property (res_valid_reg && res_reg.value > 16'hDFFF |->
        res_reg.value[15:4] == 12'hFF0 && res_reg.value[3:0] != 4'h0)
        else $error("result out of range");
    second_clean_a: assert property (res_valid_reg && res_reg.second_path
        |-> res_reg.value <= 16'hDFFF) else $error("second path result compared");
    one_done_a: assert property (one_go |-> ##[OD_LO:OD_HI] done_reg)
        else $error("single cell second path done late");
    all_done_a: assert property (all_go |-> ##[AD_LO:AD_HI] done_reg)
        else $error("all cell second path done late");
    pins_switch_a: assert property (one_go |-> ##[PS_LO:PS_HI] use_second_pins_reg)
        else $error("second pins never selected");
    path_group_a: assert property (res_valid_reg |->
        res_reg.second_path == use_second_pins_reg)
        else $error("result group does not match pin path");
endmodule
bind arc_checker arc_checker_asserts #(.ALL_SLOT_CYC(ALL_SLOT_CYC), .ALL_DONE_CYC(ALL_DONE_CYC),
    .ALL_DONE_MCAL_CYC(ALL_DONE_MCAL_CYC), .ONE_SLOT_CYC(ONE_SLOT_CYC),
    .ONE_DONE_CYC(ONE_DONE_CYC), .ONE_DONE_MCAL_CYC(ONE_DONE_MCAL_CYC)) u_asserts (.*);

// ### verification/arc_decim_model.sv
`timescale 1ns/1ps
// decimator pair: one finished word every GAP cycles while busy
module arc_decim_model #(
    parameter int GAP = 20
) (
    input wire logic mclk,
    input wire logic busy,
    input wire logic [15:0] p_val,
    input wire logic [15:0] r_val,
    output logic conv_done,
    output logic [15:0] primary_word,
    output logic [15:0] redundant_word
);
    int cnt = 0; // cycles into the current measurement
    // pacing of measurements; restarts whenever idle
    always @(posedge mclk)
    begin
        cnt <= busy ? (cnt + 1) % GAP : 0;
        conv_done <= busy && cnt == GAP - 1;
    end
    // words only meaningful with the done pulse; inverted otherwise
    assign primary_word = conv_done ? p_val : ~p_val;
    assign redundant_word = conv_done ? r_val : ~r_val;
endmodule

// ### verification/adc_redundancy_checker_bench.sv
`timescale 1ns/1ps
module adc_redundancy_checker_bench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    arc_pkg::arc_req_t cmd_req = '0;
    logic dis_bit = 1'b0;
    logic sp_bit = 1'b0;
    logic frc_bit = 1'b0;
    logic mod_bit = 1'b0;
    logic mod_v = 1'b0;
    logic [15:0] p_val = 16'h0000;
    logic [15:0] r_val = 16'h0000;
    logic conv_done, busy, done, res_v;
    logic [15:0] pw, rw;
    arc_pkg::arc_res_t res;
    logic [15:0] exp_q[$]; // expected words of all but second-path cell commands
    logic [15:0] exp_w;
    logic [15:0] p, m;
    int n_fail = 0;
    int num_checks = 0;
    always #25 mclk = ~mclk;
    // single-cell multi-cal keeps its full default length
    arc_checker #(.ALL_SLOT_CYC(240), .ALL_DONE_CYC(400), .ALL_DONE_MCAL_CYC(800),
        .ONE_SLOT_CYC(40), .ONE_DONE_CYC(100)) u_dut (.mclk(mclk),
        .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
        .redundancy_disable_bit(dis_bit), .second_path_convert_bit(sp_bit),
        .force_redundancy_fail_bit(frc_bit), .mod_bit(mod_bit), .mod_bit_valid(mod_v),
        .conv_done(conv_done), .primary_word(pw), .redundant_word(rw), .primary_feed_reg(),
        .redundant_feed_reg(), .feed_valid_reg(), .use_second_pins_reg(), .busy_reg(busy),
        .done_reg(done), .res_valid_reg(res_v), .res_reg(res));
    arc_decim_model u_dec (.mclk(mclk), .busy(busy), .p_val(p_val), .r_val(r_val),
        .conv_done(conv_done), .primary_word(pw), .redundant_word(rw));
    // cell-measuring kinds skip the compare in second-path mode
    function automatic logic is_cell(arc_pkg::arc_cmd_t k);
        return k inside {4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
    endfunction
    function automatic logic [15:0] expect_val(arc_pkg::arc_cmd_t k, logic [15:0] a,
        logic [15:0] b);
        logic chk;
        chk = !dis_bit && !(k inside {4'hA, 4'hB}) && !(sp_bit && is_cell(k));
        if (chk && frc_bit)
            return arc_pkg::ARC_FAULT_BASE | 16'(arc_pkg::ARC_FORCE_FLAGS);
        if (chk && a !== b)
            return {12'hFF0, a[15:12] != b[15:12], a[11:8] != b[11:8],
                a[7:4] != b[7:4], a[3:0] != b[3:0]};
        return (a > arc_pkg::ARC_MAX_VALID) ? arc_pkg::ARC_MAX_VALID : a;
    endfunction
    // one command, held a single cycle, then wait for completion
    task automatic run(arc_pkg::arc_cmd_t k, logic all, logic mcal, logic [15:0] a,
        logic [15:0] b);
        int w;
        @(negedge mclk);
        p_val = a;
        r_val = b;
        cmd_req = '{k, all, mcal};
        if (!(sp_bit && is_cell(k)))
            exp_q.push_back(expect_val(k, a, b));
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        w = 0;
        while (done !== 1'b1 && w < 9000)
        begin
            @(negedge mclk);
            w++;
        end
        if (w >= 9000)
        begin
            n_fail++;
            $display("[FAIL] %0t done %h exp %h", $time, done, 1'b1);
        end
    endtask
    task finish_test;
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // random modulator stream, so the feed copies see real traffic
    always @(negedge mclk)
    begin
        mod_bit <= 1'($urandom);
        mod_v <= 1'($urandom);
    end
    // result watcher; second-path words fall back to the clamped primary
    always @(negedge mclk)
    begin
        if (res_v === 1'b1)
        begin
            num_checks++;
            exp_w = exp_q.size() ? exp_q.pop_front() : (p_val > 16'hDFFF ? 16'hDFFF : p_val);
            if (res.value !== exp_w)
                $display("[FAIL] %0t exp %h got %h", $time, exp_w, res.value);
            if (res.value !== exp_w)
                n_fail++;
        end
    end
    // hang guard, far beyond the ten thousand or so cycles the tests need
    initial
    begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        finish_test;
    end
    initial
    begin
        void'($urandom(95013));
        repeat (12) @(posedge mclk);
        @(negedge mclk) sys_rst = 1'b0;
        for (int k = 0; k < 12; k++)
        begin
            p = 16'($urandom % 32'hE000);
            m = 16'($urandom) | (16'h0001 << (k % 16));
            run(arc_pkg::arc_cmd_t'(k), 1'b0, 1'b0, p, p ^ m);
        end
        run(arc_pkg::ARC_CMD_CELL, 1'b0, 1'b0, 16'hFFFF, 16'hFFFF);
        frc_bit = 1'b1;
        run(arc_pkg::ARC_CMD_CELL, 1'b0, 1'b0, 16'h1234, 16'h1234);
        run(arc_pkg::ARC_CMD_AUXD, 1'b0, 1'b0, 16'h0F0F, 16'h0F0E);
        frc_bit = 1'b0;
        dis_bit = 1'b1;
        run(arc_pkg::ARC_CMD_CELL, 1'b0, 1'b0, 16'hABCD, 16'h0000);
        run(arc_pkg::ARC_CMD_STATD, 1'b0, 1'b0, 16'h5555, 16'hAAAA);
        dis_bit = 1'b0;
        sp_bit = 1'b1;
        for (int c = 0; c < 4; c++)
            run(arc_pkg::ARC_CMD_CELL, c[1], c[0], 16'h2468, 16'h8642);
        run(arc_pkg::ARC_CMD_AUXD, 1'b0, 1'b0, 16'h1111, 16'h1011);
        sp_bit = 1'b0;
        finish_test;
    end
endmodule
